// ### rslm_cfg.svh
/*
  constants for the resolver signal-loss monitor: register offsets, fault bit positions,
  reset values, loop gains and timing counts. assumes a 100 MHz system clock.
*/
`ifndef RSLM_CFG_SVH
`define RSLM_CFG_SVH
`define RSLM_ADDR_LOS_THR     8'h88
`define RSLM_ADDR_FAULT       8'hff
`define RSLM_LOS_THR_RST      8'h20
`define RSLM_FLT_CLIP         7
`define RSLM_FLT_BELOW        6
`define RSLM_FLT_OPEN         5
`define RSLM_FLT_DOS          3
`define RSLM_FLT_LOT          2
`define RSLM_FLT_PARITY       0
`define RSLM_WIN_CYCLES       16'd256
`define RSLM_CLIP_TIME_NS     4000
`define RSLM_CLK_PERIOD_NS    10
`define RSLM_CLIP_CYCLES      ((`RSLM_CLIP_TIME_NS + `RSLM_CLK_PERIOD_NS - 1) / `RSLM_CLK_PERIOD_NS)
`define RSLM_GAIN_P           4
`define RSLM_GAIN_I           10
`endif

// ### rslm_pkg.sv
/*
  types for the resolver signal-loss monitor.
  assumes rslm_cfg.svh is compiled alongside.
*/
package rslm_pkg;
  typedef enum logic [3:0] {
    RSLM_MODE_POS    = 4'b0001,
    RSLM_MODE_VEL    = 4'b0010,
    RSLM_MODE_RSVD   = 4'b0100,
    RSLM_MODE_CONFIG = 4'b1000
  } rslm_mode_t;
  typedef logic [7:0] rslm_byte_t;
  typedef logic signed [15:0] rslm_samp_t;
endpackage

// ### rslm_sincos.sv
/*
  sine/cosine of a 16-bit angle by a 64-entry quarter-wave table.
  assumes the caller registers the outputs where timing matters.
*/
`timescale 1ns/1ps
`default_nettype none
module rslm_sincos
  import rslm_pkg::*;
(
  input  wire logic [15:0]       angle_i,  // angle, full turn = 2^16
  output logic signed [15:0]     sin_o,    // sine, q1.15
  output logic signed [15:0]     cos_o     // cosine, q1.15
);
  function automatic logic [14:0] rslm_quarter(input logic [5:0] idx);
    logic [14:0] tbl [0:63];
    for (int k = 0; k < 64; k++)
    begin
      tbl[k] = 15'(int'($sin((k + 0.5) * 3.14159265358979 / 128.0) * 32767.0));
    end
    return tbl[idx];
  endfunction

  function automatic logic signed [15:0] rslm_sin(input logic [15:0] a);
    logic [5:0]  i;
    logic [14:0] m;
    i = a[14] ? ~a[13:8] : a[13:8];
    m = rslm_quarter(i);
    return a[15] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  wire [15:0] cos_angle = angle_i + 16'h4000;
  assign sin_o = rslm_sin(angle_i);
  assign cos_o = rslm_sin(cos_angle);
endmodule // rslm_sincos
`default_nettype wire

// ### rslm_top.sv
/*
  tracking resolver-to-digital loop with signal-loss monitor and fault pins, latched except for tracking loss.
  assumes demodulated signed samples of each input pin on the system clock, a host
  register port (address, write, read strobe) and mode pins from outside the domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rslm_cfg.svh"
// Operation
// - angle output steps one lsb per lsb turned
// - error is sin*cos(phi) minus cos*sin(phi), nulled
// - type two loop, two integrators
// - monitor compares position register with inputs
// - monitor is sin*sin(phi) plus cos*cos(phi)
// - matched inputs give constant monitor magnitude
// - mismatched inputs swing monitor at twice rotation
// - loss when input below threshold register 0x88
// - loss when an input pin is open
// - loss when an input pin clips a rail
// - loss on configuration parity error
// - loss drives both fault pins low, latched
// - config-mode fault register read releases pins
// - loss has priority over degradation and tracking
// - below-threshold latency up to two window periods
// - pins encode loss, degradation, tracking, none
module rslm_top
  import rslm_pkg::*;
#(
  parameter int RES_BITS = 16               // selected resolution
)(
  input  wire logic                clk_i,                  // 100 MHz clock
  input  wire logic                rst_i,                  // sync reset, high
  input  wire rslm_pkg::rslm_samp_t sine_in_i,             // demodulated sine
  input  wire rslm_pkg::rslm_samp_t cosine_in_i,           // demodulated cosine
  input  wire logic [3:0]          pin_open_i,             // open-pin detect, async
  input  wire logic [3:0]          pin_clip_i,             // rail clip detect, async
  input  wire logic                degradation_cond_i,     // degradation condition
  input  wire logic                mode_select_low_i,      // mode pin 0, async
  input  wire logic                mode_select_high_i,     // mode pin 1, async
  input  wire logic [7:0]          reg_addr_i,             // register address
  input  wire logic [7:0]          reg_wdata_i,            // write data
  input  wire logic                reg_wr_i,               // write strobe
  input  wire logic                reg_rd_i,               // read strobe
  output logic [7:0]               reg_rdata_o,            // read data
  output logic [15:0]              angle_o,                // digital angle
  output logic signed [15:0]       monitor_o,              // monitor value
  output logic                     degradation_fault_out_o, // low on fault
  output logic                     tracking_loss_out_o      // low on fault
);
  import rslm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  always_ff @(posedge clk_i)
  begin
    sync1_q <= {pin_open_i, pin_clip_i, mode_select_high_i, mode_select_low_i};
    sync2_q <= sync1_q;
  end
  wire [3:0] open_s = sync2_q[9:6];
  wire [3:0] clip_s = sync2_q[5:2];
  rslm_mode_t mode;
  always_comb
  begin
    case (sync2_q[1:0])
      2'b00:   mode = RSLM_MODE_POS;
      2'b01:   mode = RSLM_MODE_VEL;
      2'b10:   mode = RSLM_MODE_RSVD;
      2'b11:   mode = RSLM_MODE_CONFIG;
      default: mode = RSLM_MODE_POS;
    endcase
  end
  wire in_config = (mode == RSLM_MODE_CONFIG);

  ////////////////////////////////////////////////////////////////////////////////
  // tracking loop
  logic [31:0]        phi_q;
  logic signed [31:0] vel_q;
  logic signed [15:0] sin_phi;
  logic signed [15:0] cos_phi;
  logic signed [15:0] mon_q;
  logic signed [15:0] err_q;
  rslm_sincos u_sincos (
    .angle_i (phi_q[31:16]),
    .sin_o   (sin_phi),
    .cos_o   (cos_phi)
  );
  wire signed [31:0] p_sc   = sine_in_i * cos_phi;
  wire signed [31:0] p_cs   = cosine_in_i * sin_phi;
  wire signed [31:0] p_ss   = sine_in_i * sin_phi;
  wire signed [31:0] p_cc   = cosine_in_i * cos_phi;
  wire signed [32:0] err_w  = 33'(p_sc) - 33'(p_cs);
  wire signed [32:0] mon_w  = 33'(p_ss) + 33'(p_cc);
  wire signed [15:0] err_d  = err_w[30:15];
  wire signed [15:0] mon_d  = mon_w[30:15];
  wire signed [31:0] vel_d  = vel_q + (32'(err_q) <<< `RSLM_GAIN_I);
  wire [31:0]        phi_d  = phi_q + 32'(vel_q) + (32'(err_q) <<< `RSLM_GAIN_P + 8);
  wire [15:0]        res_mask = 16'hffff << (16 - RES_BITS);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      phi_q <= 32'h0;
      vel_q <= 32'sh0;
      err_q <= 16'sh0;
      mon_q <= 16'sh0;
    end
    else
    begin
      err_q <= err_d;
      mon_q <= mon_d;
      vel_q <= vel_d;
      phi_q <= phi_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // window max of monitor magnitude and below-threshold check
  logic [15:0]  win_cnt_q;
  logic [7:0]   mon_max_q;
  logic         below_q;
  logic [7:0]   los_thr_q;
  wire  [15:0]  mon_abs   = mon_q[15] ? 16'(-mon_q) : 16'(mon_q);
  wire  [7:0]   mon_mag   = mon_abs[15:8];
  wire          win_end   = (win_cnt_q == `RSLM_WIN_CYCLES - 16'd1);
  always_ff @(posedge clk_i)
  begin
    if (rst_i || win_end)
    begin
      win_cnt_q <= 16'h0;
      mon_max_q <= 8'h0;
    end
    else
    begin
      win_cnt_q <= win_cnt_q + 16'd1;
      mon_max_q <= (mon_mag > mon_max_q) ? mon_mag : mon_max_q;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      below_q <= 1'b0;
    else if (win_end)
      below_q <= (mon_max_q < {1'b0, los_thr_q[6:0]});
  end

  ////////////////////////////////////////////////////////////////////////////////
  // clip persistence
  logic [9:0] clip_cnt_q;
  wire        clip_now  = |clip_s;
  wire        clip_hit  = (clip_cnt_q == 10'(`RSLM_CLIP_CYCLES));
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !clip_now)
      clip_cnt_q <= 10'h0;
    else if (!clip_hit)
      clip_cnt_q <= clip_cnt_q + 10'd1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers, parity, fault latching
  wire   thr_wr     = reg_wr_i && in_config && (reg_addr_i == `RSLM_ADDR_LOS_THR);
  wire   fault_rd   = reg_rd_i && in_config && (reg_addr_i == `RSLM_ADDR_FAULT);
  wire   parity_err = ~^los_thr_q;
  wire   lot_cond   = (err_q > 16'sh1000) || (err_q < -16'sh1000);
  wire [7:0] fault_set;
  assign fault_set[`RSLM_FLT_CLIP]   = clip_hit;
  assign fault_set[`RSLM_FLT_BELOW]  = below_q;
  assign fault_set[`RSLM_FLT_OPEN]   = |open_s;
  assign fault_set[4]                = 1'b0;
  assign fault_set[`RSLM_FLT_DOS]    = degradation_cond_i;
  assign fault_set[`RSLM_FLT_LOT]    = lot_cond;
  assign fault_set[1]                = 1'b0;
  assign fault_set[`RSLM_FLT_PARITY] = parity_err;
  logic [7:0] fault_q;
  wire [7:0]  fault_d = (fault_rd ? 8'h0 : fault_q) | fault_set;
  wire los_d = fault_d[`RSLM_FLT_CLIP] | fault_d[`RSLM_FLT_BELOW] |
               fault_d[`RSLM_FLT_OPEN] | fault_d[`RSLM_FLT_PARITY];
  wire dos_d = fault_d[`RSLM_FLT_DOS];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      los_thr_q <= `RSLM_LOS_THR_RST;
      fault_q   <= 8'h0;
    end
    else
    begin
      if (thr_wr)
        los_thr_q <= {~^reg_wdata_i[6:0], reg_wdata_i[6:0]};
      fault_q <= fault_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  wire [7:0] rdata_d = fault_rd ? fault_q :
                       (reg_addr_i == `RSLM_ADDR_LOS_THR) ? los_thr_q : 8'h0;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      degradation_fault_out_o <= 1'b1;
      tracking_loss_out_o     <= 1'b1;
      reg_rdata_o             <= 8'h0;
      angle_o                 <= 16'h0;
      monitor_o               <= 16'sh0;
    end
    else
    begin
      degradation_fault_out_o <= ~(los_d | dos_d);
      tracking_loss_out_o     <= ~(los_d | (!dos_d && lot_cond));
      if (reg_rd_i)
        reg_rdata_o <= rdata_d;
      angle_o   <= phi_q[31:16] & res_mask;
      monitor_o <= mon_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  los_both_low_a: assert property (los_d |=> !degradation_fault_out_o && !tracking_loss_out_o)
    else $error("loss did not pull both pins low");
  los_latched_a: assert property (los_d && !fault_rd ##1 !fault_rd |=> !degradation_fault_out_o)
    else $error("loss pin not held");
  rd_release_a: assert property (fault_rd && fault_set == 8'h0 |=> ##1
                                 degradation_fault_out_o && tracking_loss_out_o)
    else $error("fault read did not release pins");
  lot_only_a: assert property (!los_d && !dos_d && lot_cond |=>
                               degradation_fault_out_o && !tracking_loss_out_o)
    else $error("tracking loss encoding wrong");
  dos_prio_a: assert property (!los_d && dos_d |=> !degradation_fault_out_o && tracking_loss_out_o)
    else $error("degradation priority wrong");
  open_flag_a: assert property ((|open_s) |=> fault_q[`RSLM_FLT_OPEN])
    else $error("open pin not flagged");
  clip_flag_a: assert property (clip_hit |=> fault_q[`RSLM_FLT_CLIP])
    else $error("clip not flagged");
  below_win_a: assert property (win_end && mon_max_q < {1'b0, los_thr_q[6:0]} |=> below_q)
    else $error("below threshold not caught at window end");
  angle_res_a: assert property ((angle_o & ~res_mask) == 16'h0)
    else $error("angle has bits below resolution");
  set_wins_a: assert property (fault_rd && fault_set[`RSLM_FLT_OPEN] |=> fault_q[`RSLM_FLT_OPEN])
    else $error("set lost under clear");
  los_cov: cover property (los_d ##1 !degradation_fault_out_o);
  rel_cov: cover property (fault_rd ##2 degradation_fault_out_o);
  lot_cov: cover property (!tracking_loss_out_o && degradation_fault_out_o);
endmodule // rslm_top
`default_nettype wire

// ### rslm_resolver_model.sv
/*
  resolver winding model: demodulated sine and cosine samples for a shaft angle.
  assumes the bench sets angle and amplitude at the falling edge of the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module rslm_resolver_model
  import rslm_pkg::*;
(
  input  wire logic [15:0]    angle_i,  // shaft angle, full turn 2^16
  input  wire logic [15:0]    amp_i,    // winding amplitude
  output rslm_pkg::rslm_samp_t sine_o,   // amp * sin
  output rslm_pkg::rslm_samp_t cosine_o  // amp * cos
);
  real ph;
  always_comb
  begin
    ph = 6.283185307 * angle_i / 65536.0;
    sine_o = 16'($rtoi(amp_i * $sin(ph)));
    cosine_o = 16'($rtoi(amp_i * $cos(ph)));
  end
endmodule // rslm_resolver_model
`default_nettype wire

// ### rslm_top_tb.sv
/*
  self-checking bench for rslm_top: register reads and writes, tracking, fault pins.
  assumes rslm_cfg.svh, rslm_pkg and the resolver model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module rslm_top_tb;
  import rslm_pkg::*;
  logic clk_i = 0, rst_i = 1, deg_i = 0, mlo = 0, mhi = 0, wr = 0, rd = 0;
  logic [3:0] open_i = 0, clip_i = 0;
  logic [7:0] addr = 0, wd = 0, rdata, d;
  logic [15:0] ang, theta = 0, amp = 0;
  logic signed [15:0] mon;
  logic degp, trkp;
  rslm_samp_t s, c;
  int bad_count = 0, compares = 0;
  always #5 clk_i = ~clk_i;
  rslm_resolver_model res (.angle_i(theta), .amp_i(amp), .sine_o(s), .cosine_o(c));
  rslm_top uut (.clk_i(clk_i), .rst_i(rst_i), .sine_in_i(s), .cosine_in_i(c), .pin_open_i(open_i),
    .pin_clip_i(clip_i), .degradation_cond_i(deg_i), .mode_select_low_i(mlo), .mode_select_high_i(mhi),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .angle_o(ang), .monitor_o(mon), .degradation_fault_out_o(degp), .tracking_loss_out_o(trkp));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input logic [15:0] got, input logic [15:0] exp, input int tol);
    logic signed [15:0] df;
    df = got - exp;
    check(16'(df > tol || df < -tol), 16'h0000);
  endtask
  task automatic conclude();
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic mode(input logic h, input logic l);
    mhi = h;
    mlo = l;
    cyc(4);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    addr = a;
    wd = v;
    wr = 1;
    cyc(1);
    wr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    cyc(1);
    v = rdata;
  endtask
  task automatic pins(input logic [1:0] e);
    check({14'h0, degp, trkp}, {14'h0, e});
  endtask
  // read the cause in configuration mode and expect the pins released
  task automatic clr(input int b);
    mode(1, 1);
    rreg(8'hff, d);
    check(d[b], 1'b1);
    cyc(3);
    pins(2'b11);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(10);
    rst_i = 0;
    cyc(1);
    pins(2'b11);
    mode(1, 1);
    rreg(8'h88, d);
    check(d, 8'h20);
    wreg(8'h88, 8'h05);
    rreg(8'h88, d);
    check(d, 8'h85);
    mode(0, 0);
    wreg(8'h88, 8'h7f);
    rreg(8'h88, d);
    check(d, 8'h85);
    rreg(8'h10, d);
    check(d, 8'h00);
    mode(1, 1);
    wreg(8'h88, 8'h20);
    amp = 16'h4000;
    theta = 16'h4000;
    cyc(20000);
    near(ang, theta, 16'h0040);
    near(mon, amp, 16'h0300);
    rreg(8'hff, d);
    cyc(3);
    pins(2'b11);
    repeat (2000)
    begin
      theta = theta + 16'h0001;
      cyc(4);
    end
    near(ang, theta, 16'h0080);
    for (int k = 0; k < 4; k++)
    begin
      mode(0, 0);
      open_i[k] = 1;
      cyc(4);
      open_i[k] = 0;
      cyc(6);
      pins(2'b00);
      rreg(8'hff, d);
      cyc(300);
      pins(2'b00);
      clr(`RSLM_FLT_OPEN);
      clip_i[k] = 1;
      cyc(390);
      clip_i[k] = 0;
      cyc(8);
      pins(2'b11);
      clip_i[k] = 1;
      cyc(410);
      clip_i[k] = 0;
      cyc(4);
      pins(2'b00);
      clr(`RSLM_FLT_CLIP);
    end
    amp = 16'h1000;
    cyc(600);
    pins(2'b00);
    amp = 16'h4000;
    cyc(600);
    clr(`RSLM_FLT_BELOW);
    deg_i = 1;
    cyc(2);
    deg_i = 0;
    cyc(4);
    pins(2'b01);
    clr(`RSLM_FLT_DOS);
    deg_i = 1;
    open_i[0] = 1;
    cyc(4);
    deg_i = 0;
    open_i[0] = 0;
    cyc(6);
    pins(2'b00);
    clr(`RSLM_FLT_OPEN);
    conclude();
  end
  initial
  begin
    cyc(60000);
    bad_count++;
    conclude();
  end
endmodule // rslm_top_tb
`default_nettype wire
